/* File: tci_regs.vh */
`ifndef TCI_REGS_VH
`define TCI_REGS_VH
// register indices; byte address is four times the index
`define TCI_IDX_FREE_LOW 6'h20
`define TCI_IDX_FREE_HIGH 6'h21
`define TCI_IDX_CAP_A_RISE 6'h22
`define TCI_IDX_CAP_B_RISE 6'h23
`define TCI_IDX_CAP_A_FALL 6'h24
`define TCI_IDX_CAP_B_FALL 6'h25
`define TCI_IDX_IVL_CNT_LOW 6'h26
`define TCI_IDX_IVL_CNT_HIGH 6'h27
`define TCI_IDX_IVL_RLD_LOW 6'h28
`define TCI_IDX_IVL_RLD_HIGH 6'h29
`define TCI_IDX_TIMER_SETUP 6'h2a
`define TCI_IDX_CAP_ENABLE 6'h2b
`define TCI_IDX_CAP_FLAGS 6'h2c
// timer_setup fields
`define TCI_SETUP_FIRST_EDGE 7
`define TCI_SETUP_PRESCALE_HI 6
`define TCI_SETUP_PRESCALE_LO 4
`define TCI_SETUP_WIDE 3
`define TCI_SETUP_MASK 8'hf8
// capture flag / enable bit positions
`define TCI_FLAG_A_RISE 0
`define TCI_FLAG_A_FALL 1
`define TCI_FLAG_B_RISE 2
`define TCI_FLAG_B_FALL 3
// reset values
`define TCI_RST_BYTE 8'h00
`define TCI_RST_NIBBLE 4'h0
`define TCI_RST_COUNT 16'h0000
`define TCI_RST_IVL 12'h000
// free counter event points
`define TCI_PERIOD_MASK 16'h0fff
`define TCI_COUNT_MAX 16'hffff
// bus responses
`define TCI_RESP_OKAY 2'b00
`define TCI_RESP_SLVERR 2'b10
// timing: system clock, nominal capture clock, interval tick
`define TCI_CLK_MHZ 25
`define TCI_TCAP_MHZ 4
`define TCI_TCAP_DIV ((`TCI_CLK_MHZ + `TCI_TCAP_MHZ - 1) / `TCI_TCAP_MHZ)
`define TCI_IVL_TICK_US 1
`define TCI_IVL_DIV (`TCI_IVL_TICK_US * `TCI_CLK_MHZ)
`endif

/* File: tci_timer.v */
// Overview of operation
// RULE_01 - sixteen-bit free counter counts up on each capture clock tick, readable
// RULE_02 - timer ticks come from a divider enable; register access stays glitch free
// RULE_03 - reading counter low byte latches high byte for a later high read
// RULE_04 - counter sampled on low read; written only when high byte written
// RULE_05 - software reads and writes the counter low byte before high byte
// RULE_06 - periodic event every 4096 capture clock ticks
// RULE_07 - wrap event each time the counter rolls over its maximum
// RULE_08 - rising edge of input a stores counter into capture a rise
// RULE_09 - falling edge of input a stores counter into capture a fall
// RULE_10 - narrow mode captures take the counter slice picked by prescale
// RULE_11 - wide mode capture a registers hold low counter byte
// RULE_12 - narrow mode input b edges load capture b rise and fall
// RULE_13 - wide mode capture b rise holds high byte of input a rise
// RULE_14 - wide mode capture b fall holds high byte of input a fall
// RULE_15 - twelve-bit interval timer; low read latches upper nibble
// RULE_16 - interval high read returns latched nibble, upper bits zero
// RULE_17 - interval count registers ignore software writes
// RULE_18 - software writes reload low byte before reload high nibble
// RULE_19 - interval timer counts at fixed tick, reloads at terminal, raises event
// RULE_20 - capture inputs synchronised and edge detected before loading
// RULE_21 - prescale n selects counter bits seven plus n down to n
// RULE_22 - wide select disables capture b; its registers extend capture a
// RULE_23 - first-edge option keeps first capture until read, else latest
// RULE_24 - each capture edge sets a flag; writing one clears it
//
// Design decision made here: the AXI4-Lite slave port.
`include "tci_regs.vh"
`default_nettype none
module tci_timer #(
  parameter [7:0] TCAP_DIV = `TCI_TCAP_DIV,
  parameter [7:0] IVL_DIV = `TCI_IVL_DIV
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire capture_input_a,
  input wire capture_input_b,
  output reg period_evt,
  output reg wrap_evt,
  output reg interval_evt,
  output reg capture_a_irq,
  output reg capture_b_irq
);

  // counter slice for narrow capture: value n picks bits [7+n:n]
  function [7:0] tci_slice;
    input [15:0] cnt;
    input [2:0] sel;
    reg [15:0] shifted;
    begin
      shifted = cnt >> sel;
      tci_slice = shifted[7:0];
    end
  endfunction

  // register index decode shared by the read and write paths
  function tci_mapped;
    input [5:0] idx;
    begin
      tci_mapped = (idx >= `TCI_IDX_FREE_LOW) && (idx <= `TCI_IDX_CAP_FLAGS);
    end
  endfunction

  reg [15:0] free_count;
  reg [7:0] free_hold_high;
  reg [7:0] free_write_low;
  reg [7:0] capture_a_rise;
  reg [7:0] capture_b_rise;
  reg [7:0] capture_a_fall;
  reg [7:0] capture_b_fall;
  reg [11:0] interval_count;
  reg [3:0] interval_hold_high;
  reg [7:0] interval_reload_low;
  reg [3:0] interval_reload_high;
  reg [7:0] timer_setup;
  reg [3:0] capture_enable;
  reg [3:0] capture_event_flags;
  reg [3:0] held;
  reg [7:0] tcap_div_cnt;
  reg [7:0] ivl_div_cnt;
  reg tcap_tick;
  reg ivl_tick;

  // write channel holding: address and data may arrive in either order
  reg aw_full;
  reg w_full;
  reg [5:0] aw_idx;
  reg [7:0] w_byte;
  reg w_lane;

  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire do_write = aw_full & w_full & ~s_axi_bvalid;
  wire wr_ok = do_write & w_lane & tci_mapped(aw_idx);
  wire do_read = s_axi_arvalid & s_axi_arready;
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  wire rd_ok = do_read & tci_mapped(ar_idx);

  wire first_edge = timer_setup[`TCI_SETUP_FIRST_EDGE];
  wire wide_capture_select = timer_setup[`TCI_SETUP_WIDE];
  wire [2:0] prescale = timer_setup[`TCI_SETUP_PRESCALE_HI:`TCI_SETUP_PRESCALE_LO];

  // capture clock and interval tick enables from one system clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      tcap_div_cnt <= 8'h00;
      ivl_div_cnt <= 8'h00;
      tcap_tick <= 1'b0;
      ivl_tick <= 1'b0;
    end else begin
      tcap_tick <= (tcap_div_cnt == TCAP_DIV - 8'h01); // RULE_02
      ivl_tick <= (ivl_div_cnt == IVL_DIV - 8'h01); // RULE_19
      if (tcap_div_cnt == TCAP_DIV - 8'h01) begin
        tcap_div_cnt <= 8'h00;
      end else begin
        tcap_div_cnt <= tcap_div_cnt + 8'h01;
      end
      if (ivl_div_cnt == IVL_DIV - 8'h01) begin
        ivl_div_cnt <= 8'h00;
      end else begin
        ivl_div_cnt <= ivl_div_cnt + 8'h01;
      end
    end
  end

  // capture input synchronisers; first stage feeds only the second
  wire [1:0] pin_in = {capture_input_b, capture_input_a};
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg meta;
      reg stable;
      reg last;
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta <= 1'b0;
          stable <= 1'b0;
          last <= 1'b0;
        end else begin
          meta <= pin_in[gi]; // RULE_20
          stable <= meta;
          last <= stable;
        end
      end
      assign pin_rise[gi] = stable & ~last; // RULE_20
      assign pin_fall[gi] = ~stable & last;
    end
  endgenerate

  // capture loads; wide mode slaves capture b to input a, first-edge gates reloads
  wire load_ar = pin_rise[0] & ~(first_edge & held[`TCI_FLAG_A_RISE]); // RULE_08 RULE_23
  wire load_af = pin_fall[0] & ~(first_edge & held[`TCI_FLAG_A_FALL]); // RULE_09 RULE_23
  wire load_br = wide_capture_select ? load_ar :
                 pin_rise[1] & ~(first_edge & held[`TCI_FLAG_B_RISE]); // RULE_12 RULE_22
  wire load_bf = wide_capture_select ? load_af :
                 pin_fall[1] & ~(first_edge & held[`TCI_FLAG_B_FALL]); // RULE_12 RULE_22
  wire [7:0] narrow_val = tci_slice(free_count, prescale); // RULE_10 RULE_21
  wire [7:0] a_val = wide_capture_select ? free_count[7:0] : narrow_val; // RULE_11
  wire [7:0] b_val = wide_capture_select ? free_count[15:8] : narrow_val; // RULE_13 RULE_14

  // edge events per flag; capture b raises none in wide mode
  wire [3:0] edge_evt = {pin_fall[1] & ~wide_capture_select, pin_rise[1] & ~wide_capture_select,
                         pin_fall[0], pin_rise[0]};
  wire [3:0] load_vec = {load_bf, load_br, load_af, load_ar};
  wire [3:0] read_vec = {rd_ok && ar_idx == `TCI_IDX_CAP_B_FALL,
                         rd_ok && ar_idx == `TCI_IDX_CAP_B_RISE,
                         rd_ok && ar_idx == `TCI_IDX_CAP_A_FALL,
                         rd_ok && ar_idx == `TCI_IDX_CAP_A_RISE};
  wire [3:0] flag_clear = (wr_ok && aw_idx == `TCI_IDX_CAP_FLAGS) ? w_byte[3:0] : 4'h0;

  // capture registers, hold markers and event flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      capture_a_rise <= `TCI_RST_BYTE;
      capture_b_rise <= `TCI_RST_BYTE;
      capture_a_fall <= `TCI_RST_BYTE;
      capture_b_fall <= `TCI_RST_BYTE;
      held <= 4'h0;
      capture_event_flags <= 4'h0;
    end else begin
      // edge load wins over a software write in the same cycle
      if (load_ar) begin
        capture_a_rise <= a_val; // RULE_08
      end else if (wr_ok && aw_idx == `TCI_IDX_CAP_A_RISE) begin
        capture_a_rise <= w_byte;
      end
      if (load_af) begin
        capture_a_fall <= a_val; // RULE_09
      end else if (wr_ok && aw_idx == `TCI_IDX_CAP_A_FALL) begin
        capture_a_fall <= w_byte;
      end
      if (load_br) begin
        capture_b_rise <= b_val; // RULE_12 RULE_13
      end else if (wr_ok && aw_idx == `TCI_IDX_CAP_B_RISE) begin
        capture_b_rise <= w_byte;
      end
      if (load_bf) begin
        capture_b_fall <= b_val; // RULE_12 RULE_14
      end else if (wr_ok && aw_idx == `TCI_IDX_CAP_B_FALL) begin
        capture_b_fall <= w_byte;
      end
      // a new load sets the marker even if the register is read that cycle
      held <= (held & ~read_vec) | load_vec; // RULE_23
      // set wins over the write-one clear
      capture_event_flags <= (capture_event_flags & ~flag_clear) | edge_evt; // RULE_24
    end
  end

  // free counter: software write only lands on the high byte write
  always @(posedge aclk) begin
    if (!aresetn) begin
      free_count <= `TCI_RST_COUNT;
      free_hold_high <= `TCI_RST_BYTE;
      free_write_low <= `TCI_RST_BYTE;
      period_evt <= 1'b0;
      wrap_evt <= 1'b0;
    end else begin
      period_evt <= tcap_tick && ((free_count & `TCI_PERIOD_MASK) == `TCI_PERIOD_MASK); // RULE_06
      wrap_evt <= tcap_tick && (free_count == `TCI_COUNT_MAX); // RULE_07
      if (wr_ok && aw_idx == `TCI_IDX_FREE_LOW) begin
        free_write_low <= w_byte; // RULE_04
      end
      if (wr_ok && aw_idx == `TCI_IDX_FREE_HIGH) begin
        free_count <= {w_byte, free_write_low}; // RULE_04
      end else if (tcap_tick) begin
        free_count <= free_count + 16'h0001; // RULE_01
      end
      if (rd_ok && ar_idx == `TCI_IDX_FREE_LOW) begin
        free_hold_high <= free_count[15:8]; // RULE_03 RULE_04
      end
    end
  end

  // interval timer: counts down, reloads at zero
  wire [11:0] reload_val = {interval_reload_high, interval_reload_low};
  always @(posedge aclk) begin
    if (!aresetn) begin
      interval_count <= `TCI_RST_IVL;
      interval_hold_high <= `TCI_RST_NIBBLE;
      interval_evt <= 1'b0;
    end else begin
      interval_evt <= ivl_tick && (interval_count == `TCI_RST_IVL); // RULE_19
      if (ivl_tick) begin
        if (interval_count == `TCI_RST_IVL) begin
          interval_count <= reload_val; // RULE_19
        end else begin
          interval_count <= interval_count - 12'h001;
        end
      end
      if (rd_ok && ar_idx == `TCI_IDX_IVL_CNT_LOW) begin
        interval_hold_high <= interval_count[11:8]; // RULE_15
      end
    end
  end

  // software configuration registers; interval count registers have no write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      interval_reload_low <= `TCI_RST_BYTE;
      interval_reload_high <= `TCI_RST_NIBBLE;
      timer_setup <= `TCI_RST_BYTE;
      capture_enable <= 4'h0;
    end else if (wr_ok) begin
      case (aw_idx)
        `TCI_IDX_IVL_RLD_LOW: begin
          interval_reload_low <= w_byte;
        end
        `TCI_IDX_IVL_RLD_HIGH: begin
          interval_reload_high <= w_byte[3:0];
        end
        `TCI_IDX_TIMER_SETUP: begin
          timer_setup <= w_byte & `TCI_SETUP_MASK;
        end
        `TCI_IDX_CAP_ENABLE: begin
          capture_enable <= w_byte[3:0];
        end
        default: begin
          capture_enable <= capture_enable; // RULE_17
        end
      endcase
    end
  end

  // per channel request levels from enabled flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      capture_a_irq <= 1'b0;
      capture_b_irq <= 1'b0;
    end else begin
      capture_a_irq <= |(capture_event_flags[1:0] & capture_enable[1:0]); // RULE_24
      capture_b_irq <= |(capture_event_flags[3:2] & capture_enable[3:2]);
    end
  end

  // write channel: latch each half, answer once both are in
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= 6'h00;
      w_byte <= `TCI_RST_BYTE;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= tci_mapped(aw_idx) ? `TCI_RESP_OKAY : `TCI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data mux; reading a low byte also fires the latching above
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = `TCI_RST_BYTE;
    case (ar_idx)
      `TCI_IDX_FREE_LOW: rd_byte = free_count[7:0]; // RULE_03
      `TCI_IDX_FREE_HIGH: rd_byte = free_hold_high; // RULE_03
      `TCI_IDX_CAP_A_RISE: rd_byte = capture_a_rise;
      `TCI_IDX_CAP_B_RISE: rd_byte = capture_b_rise;
      `TCI_IDX_CAP_A_FALL: rd_byte = capture_a_fall;
      `TCI_IDX_CAP_B_FALL: rd_byte = capture_b_fall;
      `TCI_IDX_IVL_CNT_LOW: rd_byte = interval_count[7:0]; // RULE_15
      `TCI_IDX_IVL_CNT_HIGH: rd_byte = {4'h0, interval_hold_high}; // RULE_16
      `TCI_IDX_IVL_RLD_LOW: rd_byte = interval_reload_low;
      `TCI_IDX_IVL_RLD_HIGH: rd_byte = {4'h0, interval_reload_high};
      `TCI_IDX_TIMER_SETUP: rd_byte = timer_setup;
      `TCI_IDX_CAP_ENABLE: rd_byte = {4'h0, capture_enable};
      `TCI_IDX_CAP_FLAGS: rd_byte = {4'h0, capture_event_flags};
      default: rd_byte = `TCI_RST_BYTE;
    endcase
  end

  // read channel: one cycle latency, held until rready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TCI_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_ok ? `TCI_RESP_OKAY : `TCI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tci_timer
`default_nettype wire

/* File: tci_timer_chk.sv */
`default_nettype none
module tci_timer_chk #(
  parameter [7:0] TCAP_DIV = 8'h07,
  parameter [7:0] IVL_DIV = 8'h19
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic period_evt,
  input wire logic wrap_evt,
  input wire logic interval_evt
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [7:0] last_ar;
  // keep the read address so each answer is judged against its register
  always @(posedge aclk) begin
    if (!aresetn)
      last_ar <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      last_ar <= s_axi_araddr;
  end
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer) else $error("no write answer");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  property p_unmapped;
    s_axi_rvalid && (last_ar < 8'h80 || last_ar > 8'hb3) |->
      s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
  property p_ivl_high;
    s_axi_rvalid && last_ar == 8'h9c |-> s_axi_rdata[31:4] == 28'h0;
  endproperty
  a_ivl_high: assert property (p_ivl_high) else $error("interval high bits set");
  property p_wrap_period;
    wrap_evt |-> period_evt;
  endproperty
  a_wrap_period: assert property (p_wrap_period) else $error("wrap without period");
  property p_wrap_pulse;
    wrap_evt |=> !wrap_evt [*8];
  endproperty
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap event repeats");
  property p_period_pulse;
    period_evt |=> !period_evt [*8];
  endproperty
  a_period_pulse: assert property (p_period_pulse) else $error("period repeats");
  property p_ivl_pulse;
    interval_evt |=> !interval_evt;
  endproperty
  a_ivl_pulse: assert property (p_ivl_pulse) else $error("interval event long");
  c_wrap: cover property (wrap_evt);
  c_ivl: cover property (interval_evt);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // tci_timer_chk
bind tci_timer tci_timer_chk #(.TCAP_DIV(TCAP_DIV), .IVL_DIV(IVL_DIV)) i_chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .period_evt(period_evt), .wrap_evt(wrap_evt), .interval_evt(interval_evt));
`default_nettype wire

/* File: tci_edge_src.sv */
`default_nettype none
module tci_edge_src (
  input wire logic aclk,
  input wire logic lvl_a,
  input wire logic lvl_b,
  input wire logic slow,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly_a = 4'h0;
  logic [3:0] dly_b = 4'h0;
  // pins lag one or four cycles, so prompt and late edges both occur
  always @(posedge aclk) begin
    dly_a <= {dly_a[2:0], lvl_a};
    dly_b <= {dly_b[2:0], lvl_b};
  end
  assign pin_a = slow ? dly_a[3] : dly_a[0];
  assign pin_b = slow ? dly_b[3] : dly_b[0];
endmodule // tci_edge_src
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
`include "tci_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic lvl_a = 1'b0, lvl_b = 1'b0, slow = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic period_evt, wrap_evt, interval_evt, capture_a_irq, capture_b_irq;
  wire logic capture_input_a, capture_input_b;
  int num_errors = 0, comparisons = 0, cycles = 0;
  logic [7:0] ra [9] = '{8'h88, 8'h8c, 8'h90, 8'h94, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hb0};
  logic [7:0] ca [4] = '{8'h88, 8'h90, 8'h8c, 8'h94};

  // short divider values keep the run brief; expectations use the same values
  tci_timer #(.TCAP_DIV(8'h02), .IVL_DIV(8'h02)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .capture_input_a(capture_input_a),
    .capture_input_b(capture_input_b), .period_evt(period_evt), .wrap_evt(wrap_evt),
    .interval_evt(interval_evt), .capture_a_irq(capture_a_irq), .capture_b_irq(capture_b_irq));
  tci_edge_src i_src (.aclk(aclk), .lvl_a(lvl_a), .lvl_b(lvl_b), .slow(slow),
    .pin_a(capture_input_a), .pin_b(capture_input_b));

  initial forever #20 aclk = ~aclk;
  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] sl(input logic [15:0] v, input logic [2:0] p);
    logic [15:0] s;
    s = v >> p;
    return s[7:0];
  endfunction
  // address and data offered together; each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit aw = 0, w = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check({r, d}, {`TCI_RESP_OKAY, 24'h000000, e});
  endtask
  // low byte first, then high byte, as software must
  task automatic set_cnt(input logic [15:0] v);
    logic [1:0] r;
    wr(8'h80, v[7:0], r);
    wr(8'h84, v[15:8], r);
  endtask
  task automatic wait_ev(input int s, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(s == 0 ? interval_evt : s == 1 ? period_evt : wrap_evt));
  endtask
  // the pin settles long before the next action; 12 cycles covers sync and partner lag
  task automatic pin(input bit b, input bit v);
    @(posedge aclk);
    slow <= 1'($urandom_range(1));
    if (b)
      lvl_b <= v;
    else
      lvl_a <= v;
    repeat (12) @(posedge aclk);
  endtask

  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] wv [4];
    logic [11:0] rl;
    logic [7:0] lo;
    logic [2:0] p;
    int n, t0;
    void'($urandom(32'h2c9c2e8e));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) rc(ra[i], 8'h00);
    rd(8'hfc, d, r);
    check({r, d}, {`TCI_RESP_SLVERR, 32'h0});
    wr(8'hfc, 8'h5a, r);
    check(r, `TCI_RESP_SLVERR);
    // lane 0 strobe low: the write is answered but must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(8'ha8, 8'hff, r);
    s_axi_wstrb <= 4'hf;
    rc(8'ha8, 8'h00);
    wv[0] = 16'($urandom);
    wv[0][7:0] = 8'hf0;
    set_cnt(wv[0]);
    rd(8'h80, d, r);
    check(d[7:0] - 8'hf0 < 8'h08, 1'b1);
    repeat (40) @(posedge aclk);
    rd(8'h84, d, r);
    check(d, {24'h0, wv[0][15:8]});
    set_cnt(16'hfff8);
    wait_ev(2, n);
    check(n < 20, 1'b1);
    rd(8'h80, d, r);
    rd(8'h84, d, r);
    check(d, 32'h0);
    wait_ev(1, n);
    wait_ev(1, n);
    check(n, 4096 * 2);
    rl = {4'h1, 8'($urandom)};
    wr(8'ha0, rl[7:0], r);
    wr(8'ha4, {4'hf, rl[11:8]}, r);
    rc(8'ha4, {4'h0, rl[11:8]});
    wait_ev(0, n);
    t0 = cycles;
    wr(8'h98, 8'h00, r);
    check(r, `TCI_RESP_OKAY);
    wr(8'h9c, 8'h0f, r);
    check(r, `TCI_RESP_OKAY);
    wait_ev(0, n);
    check(cycles - t0, (rl + 1) * 2);
    rd(8'h98, d, r);
    lo = d[7:0];
    rd(8'h9c, d, r);
    check({d[3:0], lo}, rl - 12'h001);
    for (int m = 0; m < 2; m++) begin
      p = 3'(3 + $urandom_range(4));
      wr(8'ha8, m ? 8'h08 : {1'b0, p, 4'h0}, r);
      wr(8'hac, 8'h0f, r);
      for (int e = 0; e < 4; e++) begin
        wv[e] = {8'($urandom), 8'h00};
        set_cnt(wv[e]);
        pin(e[1], !e[0]);
      end
      for (int e = 0; e < 4; e++) begin
        rd(ca[e], d, r);
        if (m && e < 2)
          check(d < 8, 1'b1);
        else
          check(d, m ? wv[e - 2][15:8] : sl(wv[e], p));
      end
      rc(8'hb0, m ? 8'h03 : 8'h0f);
      check(capture_a_irq, 1'b1);
      check(capture_b_irq, !m);
      wr(8'hb0, 8'h0f, r);
      rc(8'hb0, 8'h00);
    end
    wr(8'ha8, {1'b1, p, 4'h0}, r);
    rd(8'h88, d, r);
    wv[0] = {8'($urandom), 8'h00};
    wv[1] = ~wv[0] & 16'hff00;
    set_cnt(wv[0]);
    pin(0, 1);
    pin(0, 0);
    set_cnt(wv[1]);
    pin(0, 1);
    rc(8'h88, sl(wv[0], p));
    pin(0, 0);
    set_cnt(wv[1]);
    pin(0, 1);
    rc(8'h88, sl(wv[1], p));
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
